// [exec_pkg.sv]
// constants shared by the rotate / subtract / halt execution block
// assumes a single 100 MHz core clock and an APB master for control
package exec_pkg;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int WDOG_W = 8;
  localparam int PRE_W = 8;
  // apb byte offsets
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_OPND = 8'h04;
  localparam logic [7:0] OFF_ACC = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0C;
  localparam logic [7:0] OFF_WDOG = 8'h10;
  localparam logic [7:0] OFF_FILE = 8'h14;
  // status field positions
  localparam int ST_CARRY = 0;
  localparam int ST_HALF = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_PWRDN = 3;
  localparam int ST_TMOUT = 4;
  localparam int ST_HALT = 5;
  // operand field positions
  localparam int OP_DEST = 7;
  localparam int OP_LIT_LSB = 8;
  // reset values: power-up shows both power flags set
  localparam logic [7:0] STAT_RST = 8'h18;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] WDOG_CLR = 8'h00;
  typedef enum logic [2:0] {
    OPC_NONE, OPC_ROT_L, OPC_ROT_R, OPC_SUB_LIT, OPC_HALT
  } opcode_t;
endpackage : exec_pkg

// [exec_alu.sv]
// combinational datapath for the rotate and literal subtract operations
// assumes operands are stable for the cycle they are consumed in
`timescale 1ns/1ns
module exec_alu
  import exec_pkg::*;
(
  input  wire logic [2:0] op_i,
  input  wire logic [7:0] opnd_i,
  input  wire logic [7:0] acc_i,
  input  wire logic       carry_i,
  input  wire logic [7:0] lit_i,
  output logic      [7:0] res_o,
  output logic            carry_o,
  output logic            half_o,
  output logic            zero_o
);
  logic [8:0] diff;
  logic [4:0] ndiff;
  always_comb begin
    diff    = {1'b0, lit_i} + {1'b0, ~acc_i} + 9'h001;
    ndiff   = {1'b0, lit_i[3:0]} + {1'b0, ~acc_i[3:0]} + 5'h01;
    res_o   = opnd_i;
    carry_o = carry_i;
    half_o  = 1'b0;
    zero_o  = 1'b0;
    case (op_i)
      3'(OPC_ROT_L): begin
        res_o   = {opnd_i[6:0], carry_i};
        carry_o = opnd_i[7];
      end
      3'(OPC_ROT_R): begin
        res_o   = {carry_i, opnd_i[7:1]};
        carry_o = opnd_i[0];
      end
      3'(OPC_SUB_LIT): begin
        res_o   = diff[7:0];
        carry_o = diff[8];
        half_o  = ndiff[4];
        zero_o  = (diff[7:0] == 8'h00);
      end
      default: res_o = opnd_i;
    endcase
  end
endmodule : exec_alu

// [exec_core.sv]
// execution unit for rotate-through-carry, literal subtract and halt
// assumes an APB master; holds a small 128-byte file for rotates
`timescale 1ns/1ns
module exec_core
  import exec_pkg::*;
#(
  parameter int DEPTH = 128
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic        wake_i,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             sleep_o,
  output logic             osc_stop_o
);
  import exec_pkg::*;

  // ==========================================================
  // state
  logic [7:0]         file_q [DEPTH];
  logic [7:0]         acc_q, acc_d;
  logic [7:0]         stat_q, stat_d;
  logic [WDOG_W-1:0]  wdog_q, wdog_d;
  logic [PRE_W-1:0]   pre_q, pre_d;
  logic [FADDR_W-1:0] fsel_q, fsel_d;
  logic               dest_q, dest_d;
  logic [7:0]         lit_q, lit_d;
  logic [2:0]         wake_sync_q, wake_sync_d;
  logic               wake_q, wake_d;
  logic [31:0]        prdata_d;
  logic               pslverr_d;
  logic               fwe;
  logic [7:0]         fwdata;
  logic [2:0]         op;
  logic [7:0]         alu_res;
  logic               alu_c, alu_h, alu_z;
  logic               wr, setup, cmd;

  function automatic logic hit(input logic [7:0] a);
    hit = (a == OFF_CMD) || (a == OFF_OPND) || (a == OFF_ACC) ||
          (a == OFF_STAT) || (a == OFF_WDOG) || (a == OFF_FILE);
  endfunction : hit

  // command register is write only and reads back as zero
  function automatic logic [31:0] read_word(input logic [7:0] a);
    case (a)
      OFF_OPND: read_word = {16'h0000, lit_q, dest_q, fsel_q};
      OFF_ACC:  read_word = {24'h000000, acc_q};
      OFF_STAT: read_word = {24'h000000, stat_q};
      OFF_WDOG: read_word = {16'h0000, pre_q, wdog_q};
      OFF_FILE: read_word = {24'h000000, file_q[fsel_q]};
      default:  read_word = 32'h0000_0000;
    endcase
  endfunction : read_word

  // pready is registered from the setup cycle: no wait states,
  // so every access phase ends on its first edge
  assign setup = psel && !penable;
  assign wr    = psel && penable && pready && pwrite;
  assign cmd   = wr && (paddr == OFF_CMD);
  assign op    = cmd ? pwdata[2:0] : 3'(OPC_NONE);

  exec_alu u_alu (
    .op_i    (op),
    .opnd_i  (file_q[fsel_q]),
    .acc_i   (acc_q),
    .carry_i (stat_q[ST_CARRY]),
    .lit_i   (lit_q),
    .res_o   (alu_res),
    .carry_o (alu_c),
    .half_o  (alu_h),
    .zero_o  (alu_z)
  );

  // ==========================================================
  // wake pin
  // three stages; a level counts once stages two and three agree,
  // so a one-cycle glitch never ends the halt state
  always_comb begin
    wake_sync_d = {wake_sync_q[1:0], wake_i};
    wake_d      = wake_q;
    if (wake_sync_q[1] == wake_sync_q[2]) begin
      wake_d = wake_sync_q[2];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wake_sync_q <= 3'h0;
      wake_q      <= 1'b0;
    end else begin
      wake_sync_q <= wake_sync_d;
      wake_q      <= wake_d;
    end
  end

  // ==========================================================
  // execute
  always_comb begin
    acc_d  = acc_q;
    stat_d = stat_q;
    wdog_d = wdog_q + WDOG_W'(1);
    pre_d  = pre_q;
    fsel_d = fsel_q;
    dest_d = dest_q;
    lit_d  = lit_q;
    fwe    = 1'b0;
    fwdata = alu_res;
    if (wdog_q == {WDOG_W{1'b1}}) begin
      pre_d = pre_q + PRE_W'(1);
    end
    // watchdog frozen while halted; wake only leaves the halt state
    if (stat_q[ST_HALT]) begin
      wdog_d = wdog_q;
      if (wake_q) begin
        stat_d[ST_HALT] = 1'b0;
      end
    end
    if (wr && paddr == OFF_OPND) begin
      fsel_d = pwdata[FADDR_W-1:0];
      dest_d = pwdata[OP_DEST];
      lit_d  = pwdata[OP_LIT_LSB +: 8];
    end
    if (wr && paddr == OFF_ACC) begin
      acc_d = pwdata[7:0];
    end
    if (wr && paddr == OFF_FILE) begin
      fwe    = 1'b1;
      fwdata = pwdata[7:0];
    end
    case (op)
      3'(OPC_ROT_L), 3'(OPC_ROT_R): begin
        stat_d[ST_CARRY] = alu_c;
        if (dest_q) begin
          fwe = 1'b1;
        end else begin
          acc_d = alu_res;
        end
      end
      3'(OPC_SUB_LIT): begin
        acc_d = alu_res;
        stat_d[ST_CARRY] = alu_c;
        stat_d[ST_HALF]  = alu_h;
        stat_d[ST_ZERO]  = alu_z;
      end
      3'(OPC_HALT): begin
        wdog_d = WDOG_CLR;
        pre_d = '0;
        stat_d[ST_PWRDN] = 1'b0;
        stat_d[ST_TMOUT] = 1'b1;
        stat_d[ST_HALT] = 1'b1;
      end
      default: fwe = fwe;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_q  <= ACC_RST;
      stat_q <= STAT_RST;
      wdog_q <= WDOG_CLR;
      pre_q  <= '0;
      fsel_q <= '0;
      dest_q <= 1'b0;
      lit_q  <= 8'h00;
    end else begin
      acc_q  <= acc_d;
      stat_q <= stat_d;
      wdog_q <= wdog_d;
      pre_q  <= pre_d;
      fsel_q <= fsel_d;
      dest_q <= dest_d;
      lit_q  <= lit_d;
    end
  end

  // file storage has no reset; software initialises it
  always_ff @(posedge clk_i) begin
    if (fwe) begin
      file_q[fsel_q] <= fwdata;
    end
  end

  // ==========================================================
  // apb read path
  always_comb begin
    prdata_d  = 32'h0000_0000;
    pslverr_d = 1'b0;
    if (setup && !pwrite) begin
      prdata_d = read_word(paddr);
    end
    if (setup && !hit(paddr)) begin
      pslverr_d = 1'b1;
    end
  end

  // apb outputs registered: taken in setup, standing at the access edge; sleep_o and osc_stop_o follow stat_d
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata     <= 32'h0000_0000;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      sleep_o    <= 1'b0;
      osc_stop_o <= 1'b0;
    end else begin
      prdata     <= prdata_d;
      pready     <= setup;
      pslverr    <= pslverr_d;
      sleep_o    <= stat_d[ST_HALT];
      osc_stop_o <= stat_d[ST_HALT];
    end
  end

  // ==========================================================
  // checks
  chk_halt_wdt_clear: assert property (
    @(posedge clk_i) disable iff (rst_i)
    op == 3'(OPC_HALT) |=> wdog_q == WDOG_CLR && pre_q == '0)
    else $error("watchdog not cleared on halt");
  chk_halt_flags: assert property (
    @(posedge clk_i) disable iff (rst_i)
    op == 3'(OPC_HALT) |=> !stat_q[ST_PWRDN] && stat_q[ST_TMOUT])
    else $error("power flags wrong after halt");
  chk_halt_keeps_alu: assert property (
    @(posedge clk_i) disable iff (rst_i)
    op == 3'(OPC_HALT) |=>
      stat_q[ST_ZERO:ST_CARRY] == $past(stat_q[ST_ZERO:ST_CARRY]))
    else $error("halt changed arithmetic flags");
  chk_halt_sleep: assert property (
    @(posedge clk_i) disable iff (rst_i)
    op == 3'(OPC_HALT) |=> sleep_o && osc_stop_o)
    else $error("sleep not entered after halt");
  chk_rotl_carry: assert property (
    @(posedge clk_i) disable iff (rst_i)
    op == 3'(OPC_ROT_L) |=>
      stat_q[ST_CARRY] == $past(file_q[fsel_q][7]))
    else $error("rotate left carry wrong");
  chk_rot_flags_kept: assert property (
    @(posedge clk_i) disable iff (rst_i)
    op == 3'(OPC_ROT_L) || op == 3'(OPC_ROT_R) |=>
      stat_q[ST_TMOUT:ST_HALF] == $past(stat_q[ST_TMOUT:ST_HALF]))
    else $error("rotate changed flags other than carry");
  chk_rotr_carry: assert property (
    @(posedge clk_i) disable iff (rst_i)
    op == 3'(OPC_ROT_R) |=>
      stat_q[ST_CARRY] == $past(file_q[fsel_q][0]))
    else $error("rotate right carry wrong");
  chk_rotr_acc_dest: assert property (
    @(posedge clk_i) disable iff (rst_i)
    op == 3'(OPC_ROT_R) && !dest_q |=>
      acc_q == {$past(stat_q[ST_CARRY]), $past(file_q[fsel_q][7:1])})
    else $error("rotate right result wrong");
  chk_rot_acc_dest: assert property (
    @(posedge clk_i) disable iff (rst_i)
    op == 3'(OPC_ROT_L) && !dest_q |=>
      acc_q == {$past(file_q[fsel_q][6:0]), $past(stat_q[ST_CARRY])})
    else $error("rotate left result wrong");
  chk_rot_file_dest: assert property (
    @(posedge clk_i) disable iff (rst_i)
    op == 3'(OPC_ROT_R) && dest_q |=>
      file_q[fsel_q] ==
        {$past(stat_q[ST_CARRY]), $past(file_q[fsel_q][7:1])})
    else $error("rotate result not written to file");
  chk_rot_file_kept: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (op == 3'(OPC_ROT_L) || op == 3'(OPC_ROT_R)) && !dest_q |=>
      file_q[fsel_q] == $past(file_q[fsel_q]))
    else $error("file changed by rotate to accumulator");
  chk_sub_result: assert property (
    @(posedge clk_i) disable iff (rst_i)
    op == 3'(OPC_SUB_LIT) |=>
      acc_q == 8'($past(lit_q) - $past(acc_q)))
    else $error("literal subtract result wrong");
  chk_sub_flags: assert property (
    @(posedge clk_i) disable iff (rst_i)
    op == 3'(OPC_SUB_LIT) |=>
      stat_q[ST_CARRY] == ($past(acc_q) <= $past(lit_q)) &&
      stat_q[ST_HALF] == ($past(acc_q[3:0]) <= $past(lit_q[3:0])))
    else $error("literal subtract flags wrong");
  chk_sub_zero: assert property (
    @(posedge clk_i) disable iff (rst_i)
    op == 3'(OPC_SUB_LIT) |=>
      stat_q[ST_ZERO] == ($past(acc_q) == $past(lit_q)))
    else $error("literal subtract zero flag wrong");
  // a legal master never holds setup for two cycles
  chk_ready_one_cycle: assert property (
    @(posedge clk_i) disable iff (rst_i)
    pready |=> !pready)
    else $error("pready high for more than one cycle");
  cov_rotl: cover property (@(posedge clk_i) op == 3'(OPC_ROT_L));
  cov_rotr_file: cover property (@(posedge clk_i)
    op == 3'(OPC_ROT_R) && dest_q);
  cov_sub_zero: cover property (@(posedge clk_i)
    op == 3'(OPC_SUB_LIT) && alu_z);
  cov_halt: cover property (@(posedge clk_i) op == 3'(OPC_HALT));
  cov_wake_exit: cover property (@(posedge clk_i)
    stat_q[ST_HALT] && wake_q);
endmodule : exec_core

// [tb.sv]
// self-checking bench for exec_core: apb register tests of rotate,
// literal subtract and halt; assumes exec_pkg offsets and status layout
`timescale 1ns/1ns
module tb;
  import exec_pkg::*;
  logic        clk_i   = 1'b0;
  logic        rst_i   = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic        wake_i  = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sleep_o;
  logic        osc_stop_o;
  logic [32:0] exp_q[$];
  int          error_cnt = 0;
  int          tests_run = 0;
  int          cyc       = 0;
  logic [7:0]  st, acc, fv, r, a, k;
  logic [6:0]  fa;
  logic        dst, left;

  exec_core #(.DEPTH(128)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .wake_i(wake_i),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_o(sleep_o), .osc_stop_o(osc_stop_o)
  );

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  // ==========================================
  // compare, report, bus tasks
  task automatic check(input string nm, input logic [32:0] e,
                       input logic [32:0] s);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  // one idle edge after each transfer so no signal is set twice at once
  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask : apb

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    apb(1'b1, ad, {24'h0, d});
  endtask : wr

  task automatic rd(input logic [7:0] ad, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, ad, 32'h0);
  endtask : rd

  // ==========================================
  // read monitor: oldest note against {pslverr, prdata}
  always @(posedge clk_i) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (exp_q.size() == 0) check("read note", 33'h0, 33'h1);
      else check("prdata", exp_q.pop_front(), {pslverr, prdata});
    end
  end

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      final_report();
    end
  end

  // ==========================================
  // main sequence
  initial begin
    void'($urandom(32'hDB0EB7CB));
    st = STAT_RST;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(OFF_STAT, {25'h0, st});
    rd(OFF_ACC, {25'h0, ACC_RST});
    rd(8'h18, {1'b1, 32'h0});
    $display("test reset done");
    // carry chains from one rotate to the next
    for (int i = 0; i < 12; i++) begin
      fa = (i == 0) ? 7'h00 : (i == 1) ? 7'h7F : 7'($urandom);
      dst = i[0];
      left = (i < 6);
      fv = 8'($urandom);
      acc = 8'($urandom);
      wr(OFF_OPND, {dst, fa});
      wr(OFF_FILE, fv);
      wr(OFF_ACC, acc);
      wr(OFF_CMD, left ? 8'h01 : 8'h02);
      r = left ? {fv[6:0], st[ST_CARRY]} : {st[ST_CARRY], fv[7:1]};
      st[ST_CARRY] = left ? fv[7] : fv[0];
      rd(OFF_ACC, {25'h0, dst ? acc : r});
      rd(OFF_FILE, {25'h0, dst ? r : fv});
      rd(OFF_STAT, {25'h0, st});
    end
    $display("test rotate done");
    for (int i = 0; i < 16; i++) begin
      a = 8'($urandom);
      k = (i % 3 == 0) ? a : 8'($urandom);
      if (i == 1) {a, k} = 16'h0F10;
      if (i == 2) {a, k} = 16'h100F;
      if (i == 4) {a, k} = 16'h00FF;
      wr(OFF_ACC, a);
      apb(1'b1, OFF_OPND, {16'h0, k, 8'h00});
      wr(OFF_CMD, 8'h03);
      r = k - a;
      st[ST_CARRY] = (a <= k);
      st[ST_HALF] = (a[3:0] <= k[3:0]);
      st[ST_ZERO] = (r == 8'h00);
      rd(OFF_ACC, {25'h0, r});
      rd(OFF_STAT, {25'h0, st});
      rd(OFF_OPND, {17'h0, k, 8'h00});
    end
    $display("test subtract done");
    check("sleep_o", 33'h0, sleep_o);
    wr(OFF_CMD, 8'h04);
    check("sleep osc", 33'h3, {sleep_o, osc_stop_o});
    st[ST_PWRDN] = 1'b0;
    st[ST_TMOUT] = 1'b1;
    st[ST_HALT] = 1'b1;
    repeat (20) @(posedge clk_i);
    rd(OFF_WDOG, {1'b0, 24'h0, WDOG_CLR});
    rd(OFF_STAT, {25'h0, st});
    check("sleep held", 33'h3, {sleep_o, osc_stop_o});
    // wake pin is filtered: hold it past the three-stage synchroniser
    wake_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    wake_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    check("sleep_o", 33'h0, {sleep_o, osc_stop_o});
    st[ST_HALT] = 1'b0;
    rd(OFF_STAT, {25'h0, st});
    $display("test halt done");
    final_report();
  end
endmodule : tb
